/* hw/ddr_psram_read_port.sv */
// Overview of operation
// - top command bit one means read
// - bit 46 picks array or registers
// - bit 45 picks wrapped or linear burst; register space is always linear
// - row access may start after two words
// - third word completes the word address
// - host clocks the latency; single when strobe low
// - strobe high adds one more latency count
// - latency four plus extra gives four more
// - strobe toggles with edge-aligned data bytes
// - device drives strobe during reads
// - data continues while clock runs, select low
// - wrap inside burst, linear crosses rows
// - linear read past end rolls to zero
// - bus clock may stop while deselected
// - register read: upper byte first, lower second
// - host centres write data between edges
// - strobe masks write bytes with latency
// - zero latency writes unmasked, strobe released
// - masked byte kept, unmasked byte stored
// - bit seven on line seven, down to zero
`timescale 1ns/1ps
// ************************************************************
// word buffer between the array and the bus
// ************************************************************
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage words
  logic [PW:0] wr_ptr_reg;  // extra bit tells full from empty
  logic [PW:0] rd_ptr_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (wr_ptr_reg[PW-1:0] != rd_ptr_reg[PW-1:0])
                    || (wr_ptr_reg[PW] == rd_ptr_reg[PW]);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data = mem[rd_ptr_reg[PW-1:0]];
  // pointers; flush drops everything left from an aborted burst
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
  // storage has no reset, only valid entries are ever read
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg[PW-1:0]] <= in_data;
    end
  end
endmodule : word_fifo
// ************************************************************
// device side of the strobe based ddr bus
// ************************************************************
module ddr_psram_read_port
  import psram_read_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic bus_clock,
  input wire logic cs_n,
  input wire logic [BYTE_W-1:0] dq_in,
  output logic [BYTE_W-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic rw_data_strobe_in,
  output logic rw_data_strobe_out,
  output logic rw_data_strobe_oe_n,
  input wire logic [LAT_W-1:0] latency_clocks,
  input wire logic [WSEL_W-1:0] wrap_len_sel,
  input wire logic refresh_busy,
  output logic row_open,
  output logic [ROW_W-1:0] row_open_addr,
  output logic fetch_valid,
  input wire logic fetch_ready,
  output logic [ADDR_W-1:0] fetch_addr,
  output logic fetch_space,
  input wire logic word_valid,
  output logic word_ready,
  input wire logic [WORD_W-1:0] word_data,
  output logic wr_valid,
  output logic [ADDR_W-1:0] wr_addr,
  output logic wr_space,
  output logic [WORD_W-1:0] wr_data,
  output logic [1:0] wr_byte_en,
  output logic read_underrun
);
  // ************************************************************
  // address step, shared by fetch and write paths
  // ************************************************************
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                   input logic wrap,
                                                   input logic [WSEL_W-1:0] sel);
    logic [ADDR_W-1:0] m;
    logic [ADDR_W-1:0] inc;
    m = (WRAP_MIN_WORDS << sel) - 1'b1;
    inc = a + 1'b1;
    // linear steps simply roll over at the top of the array
    if (wrap) begin
      next_addr = (a & ~m) | (inc & m);
    end else begin
      next_addr = inc;
    end
  endfunction : next_addr

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] bclk_sync_reg;  // bus clock, two stages
  logic bclk_d_reg;  // previous synchronised bus clock, for edges
  logic [1:0] cs_sync_reg;  // select, idles high
  logic [BYTE_W-1:0] dq_m_reg;  // data lines first stage
  logic [BYTE_W-1:0] dq_s_reg;  // data lines second stage
  logic [1:0] rw_data_strobe_sync_reg;  // strobe input as write mask
  // two flops on every pin; data and clock see the same delay,
  // so centred write data stays centred around the sampled edges
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bclk_sync_reg <= '0;
      bclk_d_reg <= 1'b0;
      cs_sync_reg <= 2'b11;
      dq_m_reg <= DQ_RESET;
      dq_s_reg <= DQ_RESET;
      rw_data_strobe_sync_reg <= '0;
    end else begin
      bclk_sync_reg <= {bclk_sync_reg[0], bus_clock};
      bclk_d_reg <= bclk_sync_reg[1];
      cs_sync_reg <= {cs_sync_reg[0], cs_n};
      dq_m_reg <= dq_in;
      dq_s_reg <= dq_m_reg;
      rw_data_strobe_sync_reg <= {rw_data_strobe_sync_reg[0], rw_data_strobe_in};
    end
  end
  wire bclk_s = bclk_sync_reg[1];
  wire cs_high = cs_sync_reg[1];
  wire mask_s = rw_data_strobe_sync_reg[1];
  wire rise = bclk_s && !bclk_d_reg;  // bus clock rising edge seen
  wire fall = !bclk_s && bclk_d_reg;  // bus clock falling edge seen
  wire edge_seen = rise || fall;

  // ************************************************************
  // transaction state
  // ************************************************************
  state_t state_reg;  // current phase
  state_t state_next;
  logic [CA_W-1:0] ca_reg;  // command/address shift register
  logic [2:0] byte_cnt_reg;  // command bytes taken so far
  logic [CNT_W-1:0] lat_cnt_reg;  // latency clocks counted
  logic extra_reg;  // strobe shown high during command phase
  logic is_read_reg;  // decoded direction
  logic space_reg;  // register space selected
  logic wrap_reg;  // wrapped burst selected
  logic [ADDR_W-1:0] addr_reg;  // next word address
  logic [BYTE_W-1:0] lo_hold_reg;  // lower byte waiting for the fall
  logic [BYTE_W-1:0] wr_hi_reg;  // upper write byte from the rise
  logic mask_hi_reg;  // mask of the upper write byte

  wire [CA_W-1:0] ca_full = {ca_reg[CA_W-BYTE_W-1:0], dq_s_reg};
  wire ca_last = (state_reg == ST_CMD) && edge_seen && (byte_cnt_reg == 3'(CA_BYTES - 1));
  wire ca_act = (state_reg == ST_CMD) && edge_seen && (byte_cnt_reg == 3'(CA_ACT_BYTES - 1));
  wire ca_read = ca_full[CA_READ_BIT];
  wire ca_space = ca_full[CA_SPACE_BIT];
  wire ca_wrap = ca_full[CA_BURST_BIT] != CA_BURST_LINEAR;
  wire [ADDR_W-1:0] ca_addr = {ca_full[CA_ROW_HI:CA_ROW_LO], ca_full[CA_COL_HI:0]};
  wire [CNT_W-1:0] lat_total = extra_reg ? {latency_clocks, 1'b0}
                                         : {1'b0, latency_clocks};
  // ending on the fall keeps the last latency fall out of the data phase,
  // so a latency write never stores a word from a non-data half cycle
  wire lat_done = (state_reg == ST_LAT) && fall
                  && (lat_cnt_reg == lat_total);
  wire lat_write = !space_reg;  // only latency writes carry a mask
  wire fifo_flush = cs_high;
  wire buf_valid;
  wire buf_pop = (state_reg == ST_RD) && rise;
  wire [WORD_W-1:0] buf_data;
  wire fetch_go = fetch_valid && fetch_ready;
  wire wr_step = (state_reg == ST_WR) && fall;

  // next state; select high always wins and drops the transaction
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (!cs_high) begin
          state_next = ST_CMD;
        end
      end
      ST_CMD: begin
        // zero latency register writes go straight to data
        if (ca_last) begin
          state_next = (!ca_read && ca_space) ? ST_WR : ST_LAT;
        end
      end
      ST_LAT: begin
        if (lat_done) begin
          state_next = is_read_reg ? ST_RD : ST_WR;
        end
      end
      ST_RD: state_next = ST_RD;
      ST_WR: state_next = ST_WR;
      default: state_next = ST_IDLE;
    endcase
    if (cs_high) begin
      state_next = ST_IDLE;
    end
  end

  // ************************************************************
  // sequencing registers
  // ************************************************************
  // phase, counters and decoded command fields
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      ca_reg <= '0;
      byte_cnt_reg <= '0;
      lat_cnt_reg <= '0;
      extra_reg <= 1'b0;
      is_read_reg <= 1'b0;
      space_reg <= 1'b0;
      wrap_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE) begin
        // refresh demand is fixed at select fall and shown through the command phase
        extra_reg <= refresh_busy;
        byte_cnt_reg <= '0;
        lat_cnt_reg <= '0;
      end
      if ((state_reg == ST_CMD) && edge_seen) begin
        ca_reg <= ca_full;
        byte_cnt_reg <= byte_cnt_reg + 1'b1;
      end
      if (ca_last) begin
        is_read_reg <= ca_read;
        space_reg <= ca_space;
        wrap_reg <= ca_wrap && !ca_space;
      end
      if ((state_reg == ST_LAT) && rise) begin
        lat_cnt_reg <= lat_cnt_reg + 1'b1;
      end
    end
  end

  // word address: loaded from the command, stepped per fetch or write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      addr_reg <= '0;
    end else if (ca_last) begin
      addr_reg <= ca_addr;
    end else if (fetch_go || wr_step) begin
      addr_reg <= next_addr(addr_reg, wrap_reg, wrap_len_sel);
    end
  end

  // early row activation once the first two words are in
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      row_open <= 1'b0;
      row_open_addr <= '0;
    end else begin
      row_open <= ca_act;
      if (ca_act) begin
        row_open_addr <= ca_full[ACT_ROW_HI:0];
      end
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  // the array is asked for words from the latency phase until select rises;
  // the buffer's ready only stalls returning words; fetch_valid does not wait on it, so fetches can outrun it
  assign fetch_valid = is_read_reg && !cs_high
                       && ((state_reg == ST_LAT) || (state_reg == ST_RD));
  assign fetch_addr = addr_reg;
  assign fetch_space = space_reg;

  word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) read_buf (
    .clock(clock),
    .nrst(nrst),
    .flush(fifo_flush),
    .in_valid(word_valid),
    .in_ready(word_ready),
    .in_data(word_data),
    .out_valid(buf_valid),
    .out_ready(buf_pop),
    .out_data(buf_data)
  );

  // bus drivers: strobe shows refresh need in the command phase,
  // stays low through read latency, then toggles with each byte
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dq_out <= DQ_RESET;
      dq_oe_n <= 1'b1;
      rw_data_strobe_out <= STROBE_RESET;
      rw_data_strobe_oe_n <= 1'b1;
      lo_hold_reg <= DQ_RESET;
      read_underrun <= 1'b0;
    end else begin
      read_underrun <= buf_pop && !buf_valid;
      dq_oe_n <= state_next != ST_RD;
      rw_data_strobe_oe_n <= !((state_next == ST_CMD)
                               || (state_next == ST_RD)
                               || ((state_next == ST_LAT)
                                   && (ca_last ? ca_read : is_read_reg)));
      if (state_reg == ST_CMD) begin
        rw_data_strobe_out <= extra_reg;
      end else if (state_reg == ST_LAT) begin
        rw_data_strobe_out <= 1'b0;
      end else if (buf_pop) begin
        // an empty buffer sends zeros; the underrun flag reports it
        dq_out <= buf_valid ? buf_data[WORD_W-1:BYTE_W] : DQ_RESET;
        lo_hold_reg <= buf_valid ? buf_data[BYTE_W-1:0] : DQ_RESET;
        rw_data_strobe_out <= 1'b1;
      end else if ((state_reg == ST_RD) && fall) begin
        dq_out <= lo_hold_reg;
        rw_data_strobe_out <= 1'b0;
      end
    end
  end

  // ************************************************************
  // write path
  // ************************************************************
  // upper byte on the rise, lower byte on the fall, one word per clock
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_hi_reg <= DQ_RESET;
      mask_hi_reg <= 1'b0;
      wr_valid <= 1'b0;
      wr_addr <= '0;
      wr_space <= 1'b0;
      wr_data <= '0;
      wr_byte_en <= '0;
    end else begin
      wr_valid <= wr_step;
      if ((state_reg == ST_WR) && rise) begin
        wr_hi_reg <= dq_s_reg;
        mask_hi_reg <= mask_s && lat_write;
      end
      if (wr_step) begin
        wr_addr <= addr_reg;
        wr_space <= space_reg;
        wr_data <= {wr_hi_reg, dq_s_reg};
        wr_byte_en <= ~{mask_hi_reg, mask_s && lat_write};
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking chk_clk @(posedge clock);
  endclocking
  default disable iff (!nrst);

  logic [ADDR_W-1:0] wrap_mask;
  assign wrap_mask = (WRAP_MIN_WORDS << wrap_len_sel) - 1'b1;

  a_read_decode: assert property (ca_last |=> is_read_reg == $past(ca_full[CA_READ_BIT]))
    else $error("direction not taken from top command bit");
  a_space_decode: assert property (ca_last |=> space_reg == $past(ca_full[CA_SPACE_BIT]))
    else $error("address space not taken from bit 46");
  a_latency_total: assert property ($rose(state_reg == ST_RD) |->
      $past(lat_cnt_reg) == (extra_reg ? {latency_clocks, 1'b0}
                                                : {1'b0, latency_clocks}))
    else $error("read data started after wrong latency count");
  a_strobe_rise: assert property (buf_pop |=> rw_data_strobe_out && !dq_oe_n)
    else $error("strobe not high with upper byte");
  a_low_byte: assert property (((state_reg == ST_RD) && fall && !cs_high) |=>
      !rw_data_strobe_out && (dq_out == $past(lo_hold_reg)))
    else $error("lower byte not sent on strobe fall");
  a_strobe_owned: assert property ((state_reg == ST_RD) |-> !rw_data_strobe_oe_n)
    else $error("strobe released during read data");
  a_release_cs: assert property ($rose(cs_high) |=> ##1 dq_oe_n && rw_data_strobe_oe_n)
    else $error("lines still driven after select high");
  a_wrap_bound: assert property ((fetch_go && wrap_reg) |=>
      (fetch_addr & ~wrap_mask) == ($past(fetch_addr) & ~wrap_mask))
    else $error("wrapped burst left its block");
  a_linear_roll: assert property ((fetch_go && !wrap_reg && (fetch_addr == '1)) |=>
      fetch_addr == '0)
    else $error("linear burst did not roll to address zero");
  a_write_mask: assert property ((wr_step && lat_write) |=>
      wr_valid && (wr_byte_en[0] == !$past(mask_s)))
    else $error("write mask not applied to lower byte");

  c_extra_read: cover property ($rose(state_reg == ST_RD) && extra_reg);
  c_wrap_read: cover property (fetch_go && wrap_reg);
  c_masked_write: cover property (wr_valid && (wr_byte_en != 2'b11));
  c_reg_write: cover property (wr_valid && wr_space);
endmodule : ddr_psram_read_port

/* hw/psram_read_pkg.sv */
package psram_read_pkg;
  // ************************************************************
  // bus geometry
  // ************************************************************
  localparam int BYTE_W = 8;  // width of the data lines
  localparam int WORD_W = 16;  // one word is two bus bytes
  localparam int CA_W = 48;  // three command/address words
  localparam int CA_BYTES = 6;  // bytes of the command/address phase
  localparam int CA_ACT_BYTES = 4;  // row and upper column known after these
  localparam int ADDR_W = 22;  // word address width of the array
  localparam int ROW_W = 19;  // row plus upper column address width
  localparam int LAT_W = 4;  // width of the latency setting
  localparam int CNT_W = 5;  // holds twice the largest latency
  localparam int WSEL_W = 2;  // wrap length selector width
  // ************************************************************
  // command/address field positions
  // ************************************************************
  localparam int CA_READ_BIT = 47;  // one marks a read
  localparam int CA_SPACE_BIT = 46;  // one marks register space
  localparam int CA_BURST_BIT = 45;  // burst type select
  localparam int CA_ROW_HI = 34;  // top of the row address
  localparam int CA_ROW_LO = 16;  // bottom of the upper column
  localparam int CA_COL_HI = 2;  // top of the lower column
  localparam int ACT_ROW_HI = 18;  // row field inside the first 32 bits
  localparam logic CA_BURST_LINEAR = 1'b1;  // burst bit value for linear
  // ************************************************************
  // reset values and burst sizes
  // ************************************************************
  localparam logic [BYTE_W-1:0] DQ_RESET = 8'h00;  // data lines idle value
  localparam logic STROBE_RESET = 1'b0;  // strobe idle value
  localparam logic [ADDR_W-1:0] WRAP_MIN_WORDS = 22'h000008;  // shortest wrap
  localparam int FIFO_DEPTH = 8;  // words buffered toward the bus
  // ************************************************************
  // transaction states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_LAT,
    ST_RD,
    ST_WR
  } state_t;
endpackage : psram_read_pkg

/* tb/host_master_model.sv */
`timescale 1ns/1ps
// ************************************************************
// host master: select, bus clock, data lines and write mask
// ************************************************************
module host_master_model (
  input wire logic [7:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic strobe_out,
  input wire logic strobe_oe_n,
  output logic bus_clock,
  output logic cs_n,
  output logic [7:0] dq_in,
  output logic strobe_in
);
  logic [7:0] host_dq; // host data drive, inverted once released
  logic host_mask; // host mask drive, inverted once released
  logic [8:0] tx_q[$]; // {mask, byte} for each write data half cycle
  logic [9:0] cap_q[$]; // {strobe_oe_n, strobe, dq} late in each half cycle
  // wire levels: the device wins wherever it enables its own driver
  assign dq_in = dq_oe_n ? host_dq : dq_out;
  assign strobe_in = strobe_oe_n ? host_mask : strobe_out;
  initial begin
    bus_clock = 1'b0;
    cs_n = 1'b1;
    host_dq = 8'h00;
    host_mask = 1'b0;
  end
  // one half cycle; data stands 40 ns each side of the edge
  task automatic half(input logic lvl, input logic drv, input logic msk, input logic [8:0] v);
    host_dq = drv ? v[7:0] : ~host_dq;
    host_mask = msk ? v[8] : ~host_mask;
    #40;
    bus_clock = lvl;
    #35;
    cap_q.push_back({strobe_oe_n, strobe_in, dq_in});
    #5;
  endtask : half
  // whole frame: command, latency clocks, data halves, deselect with clock low
  task automatic frame(input logic [47:0] ca, input int lat, input int dh, input logic wr,
                       input logic msk);
    cap_q.delete();
    cs_n = 1'b0;
    #80;
    for (int i = 0; i < 6; i++)
      half(~i[0], 1'b1, 1'b0, {1'b0, ca[47-8*i -: 8]});
    // a masked write drives the mask low through latency as a preamble
    for (int i = 0; i < 2 * lat; i++)
      half(~i[0], 1'b0, msk, 9'h000);
    // callers keep dh small so the array keeps room for refresh
    for (int i = 0; i < dh; i++)
      half(~i[0], wr, msk, wr ? tx_q.pop_front() : 9'h000);
    #80;
    cs_n = 1'b1;
    host_dq = ~host_dq;
    #160;
  endtask : frame
endmodule : host_master_model

/* tb/ddr_psram_read_port_test.sv */
`timescale 1ns/1ps
// ************************************************************
// self checking bench for the read port
// ************************************************************
module ddr_psram_read_port_test
  import psram_read_pkg::*;
;
  logic clock, nrst, refresh_busy, fetch_ready, word_valid; // bench driven
  logic [LAT_W-1:0] latency_clocks;
  logic [WSEL_W-1:0] wrap_len_sel;
  logic [WORD_W-1:0] word_data;
  logic bus_clock, cs_n, strobe_in, strobe_out, strobe_oe_n, dq_oe_n; // pin side
  logic [BYTE_W-1:0] dq_in, dq_out;
  logic row_open, fetch_valid, fetch_space, word_ready, wr_valid, wr_space, read_underrun;
  logic [ROW_W-1:0] row_open_addr;
  logic [ADDR_W-1:0] fetch_addr, wr_addr;
  logic [WORD_W-1:0] wr_data;
  logic [1:0] wr_byte_en;
  int err_count, comparisons, seed, underruns;
  logic [22:0] aq[$]; // fetches in flight {space, addr}
  logic [40:0] wq[$]; // writes seen {space, addr, byte_en, data}
  logic [18:0] rq[$]; // rows opened
  ddr_psram_read_port dut (.clock(clock), .nrst(nrst), .bus_clock(bus_clock), .cs_n(cs_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .rw_data_strobe_in(strobe_in),
    .rw_data_strobe_out(strobe_out), .rw_data_strobe_oe_n(strobe_oe_n),
    .latency_clocks(latency_clocks), .wrap_len_sel(wrap_len_sel),
    .refresh_busy(refresh_busy), .row_open(row_open), .row_open_addr(row_open_addr),
    .fetch_valid(fetch_valid), .fetch_ready(fetch_ready), .fetch_addr(fetch_addr),
    .fetch_space(fetch_space), .word_valid(word_valid), .word_ready(word_ready),
    .word_data(word_data), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_space(wr_space),
    .wr_data(wr_data), .wr_byte_en(wr_byte_en), .read_underrun(read_underrun));
  host_master_model host (.dq_out(dq_out), .dq_oe_n(dq_oe_n), .strobe_out(strobe_out),
    .strobe_oe_n(strobe_oe_n), .bus_clock(bus_clock), .cs_n(cs_n), .dq_in(dq_in),
    .strobe_in(strobe_in));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ************************************************************
  // array model and output monitors
  // ************************************************************
  // word content depends on space and address, so misplaced fetches show
  function automatic logic [15:0] word_of(input logic [22:0] sa);
    return {sa[7:0] ^ 8'h3c, sa[15:8] ^ {7'h00, sa[22]}};
  endfunction : word_of
  // one fetch in flight only, so the buffer can never be overrun
  always @(posedge clock) begin
    if (word_valid && word_ready) void'(aq.pop_front());
    if (fetch_valid && fetch_ready) aq.push_back({fetch_space, fetch_addr});
    if (wr_valid) wq.push_back({wr_space, wr_addr, wr_byte_en, wr_data});
    if (row_open) rq.push_back(row_open_addr);
    if (read_underrun) underruns++;
    if (cs_n) aq.delete(); // stale fetches die with the frame
    #1;
    word_valid = aq.size() > 0;
    word_data = word_valid ? word_of(aq[0]) : 16'($random(seed));
    fetch_ready = word_ready && aq.size() == 0 && ($random(seed) % 4 != 0);
  end
  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  function automatic logic [47:0] ca_of(input logic rd, sp, lin, input logic [21:0] a);
    return {rd, sp, lin, 10'h000, a[21:3], 13'h0000, a[2:0]};
  endfunction : ca_of
  // settings change after an edge, well before select falls
  task automatic setup(input logic busy, input int l, input int sel);
    @(posedge clock);
    #1;
    refresh_busy = busy;
    latency_clocks = LAT_W'(l);
    wrap_len_sel = WSEL_W'(sel);
    rq.delete();
    wq.delete();
    repeat (3) @(posedge clock);
    #1; // pins move by the same small delay after an edge
  endtask : setup
  // ************************************************************
  // transactions with expected results
  // ************************************************************
  task automatic rd(input logic sp, lin, busy, input int l, sel, input logic [21:0] a,
                    input int n);
    int lat;
    logic [21:0] wm1;
    logic [21:0] ea;
    logic [15:0] ew;
    lat = busy ? 2 * l : l;
    wm1 = 22'((8 << sel) - 1);
    setup(busy, l, sel);
    host.frame(ca_of(1'b1, sp, lin, a), lat, 2 * n, 1'b0, 1'b0);
    check(rq.pop_front(), a[21:3]);
    check(wq.size(), 0);
    for (int i = 0; i < 6; i++)
      check(host.cap_q[i][9:8], {1'b0, busy});
    for (int i = 0; i < 2 * lat; i++)
      check(host.cap_q[6+i][9:8], 2'b00);
    for (int k = 0; k < n; k++) begin
      ea = (sp || lin) ? 22'(a + k) : (a & ~wm1) | (22'(a + k) & wm1);
      ew = word_of({sp, ea});
      check(host.cap_q[6+2*lat+2*k], {2'b01, ew[15:8]});
      check(host.cap_q[7+2*lat+2*k], {2'b00, ew[7:0]});
    end
    check({dq_oe_n, strobe_oe_n}, 2'b11);
  endtask : rd
  task automatic wr(input logic sp, busy, input int l, input logic [21:0] a, input int n);
    int lat;
    logic [15:0] d;
    logic [1:0] m;
    logic [40:0] ex[$];
    lat = sp ? 0 : (busy ? 2 * l : l);
    for (int k = 0; k < n; k++) begin
      d = 16'($random(seed));
      m = sp ? 2'b00 : 2'($random(seed));
      host.tx_q.push_back({m[1], d[15:8]});
      host.tx_q.push_back({m[0], d[7:0]});
      ex.push_back({sp, 22'(a + k), ~m, d});
    end
    setup(busy, l, 0);
    host.frame(ca_of(1'b0, sp, 1'b1, a), lat, 2 * n, 1'b1, ~sp);
    check(wq.size(), n);
    for (int k = 0; k < n; k++)
      check(wq.pop_front(), ex[k]);
  endtask : wr
  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    seed = 36853;
    nrst = 1'b0;
    latency_clocks = 4'h4;
    wrap_len_sel = 2'h0;
    refresh_busy = 1'b0;
    fetch_ready = 1'b0;
    word_valid = 1'b0;
    word_data = 16'h0000;
    err_count = 0;
    comparisons = 0;
    underruns = 0;
    repeat (6) @(posedge clock);
    #1;
    nrst = 1'b1;
    check({dq_oe_n, strobe_oe_n, word_ready}, 3'h7);
    rd(1'b0, 1'b1, 1'b0, 4, 0, 22'h0001fe, 4);
    rd(1'b0, 1'b1, 1'b1, 4, 0, 22'h3ffffe, 4);
    rd(1'b1, 1'b1, 1'b0, 2, 0, 22'h000000, 2);
    for (int s = 0; s < 4; s++)
      rd(1'b0, 1'b0, s[0], 3 + s, s, 22'($random(seed)), (8 << s) + 2);
    wr(1'b0, 1'b0, 3, 22'h000100, 4);
    wr(1'b0, 1'b1, 1, 22'h3fffff, 3);
    wr(1'b1, 1'b0, 4, 22'h000001, 2);
    rd(1'b0, 1'b1, 1'b0, 1, 0, 22'h000010, 1);
    check(underruns, 0);
    conclude();
  end
  initial begin
    #300000;
    err_count++;
    conclude();
  end
endmodule : ddr_psram_read_port_test
